// *** sram_wmask_defs.vh ***
// Constants for the byte-lane write masking block
`ifndef SRAM_WMASK_DEFS_VH
`define SRAM_WMASK_DEFS_VH
`define LANE_W        9
`define BEATS_PER_BURST 4
`define BEAT_CNT_W    2
`define LAST_BEAT     2'h3
`define BEAT_STEP     2'h1
`define ORG_18        1'b0
`define ORG_36        1'b1
`endif

// *** sram_lane_merge.v ***
// Per-lane merge of a write beat into an old word under active-low lane masks
`default_nettype none
module sram_lane_merge #(
    parameter LANES = 4,
    parameter LW    = 9
) (
    // Old word, new beat and masks
    input  wire [LANES*LW-1:0] i_old,
    input  wire [LANES*LW-1:0] i_new,
    input  wire [LANES-1:0]    i_mask_n,
    // Merged word
    output wire [LANES*LW-1:0] o_merged,
    output wire                o_any
);
    genvar g;
    // Each lane taken from the beat only when its mask is low
    generate
        for (g = 0; g < LANES; g = g + 1) begin : lane
            assign o_merged[g*LW +: LW] = i_mask_n[g] ? i_old[g*LW +: LW]
                                                      : i_new[g*LW +: LW];
        end
    endgenerate
    assign o_any = ~&i_mask_n;
endmodule // sram_lane_merge
`default_nettype wire

// *** sram_byte_write_mask.v ***
// Write port of a burst SRAM with byte-lane write masking
`include "sram_wmask_defs.vh"
`default_nettype none
// Functional notes
// - 18-bit: both masks high stores nothing
// - 36-bit: all masks low stores whole beat
// - 36-bit: only mask 0 low stores [8:0]
// - 36-bit: masks 1..3 gate upper lanes
// - 36-bit: all masks high writes nothing
// - Masks evaluated per beat, both clock rises
// - Masks apply only inside write data beats
// - Beats at t+1, t+2, addresses A..A+3
// - Beats registered on both clock rises
// - Back-to-back write request is ignored
module sram_byte_write_mask #(
    parameter ADDR_W = 6,
    parameter ORG    = `ORG_36,
    parameter LANES  = 4
) (
    // Clock and reset
    input  wire                       i_clk,
    input  wire                       i_resetn,
    // Beat phase: low for the true-clock rise, high for the complementary rise
    input  wire                       i_beat_phase,
    // Write request with latched burst address
    input  wire                       i_write_port_select_n,
    input  wire [ADDR_W-1:0]          i_addr,
    // Write data and lane masks
    input  wire [LANES*`LANE_W-1:0]   i_data,
    input  wire                       i_lane_mask_0_n,
    input  wire                       i_lane_mask_1_n,
    input  wire                       i_lane_mask_2_n,
    input  wire                       i_lane_mask_3_n,
    // Read-back port of the array
    input  wire [ADDR_W-1:0]          i_rd_addr,
    output reg  [LANES*`LANE_W-1:0]   o_rd_data,
    // Status
    output reg                        o_write_active,
    output reg                        o_write_ignored
);
    // ----------------------------------------
    // Sizes and sequencer states
    // ----------------------------------------
    localparam DW     = LANES*`LANE_W;
    localparam S_IDLE = 1'b0;             // Waiting for a request on a true rise
    localparam S_DATA = 1'b1;             // Wait slot, then the four data beats

    // ----------------------------------------
    // Lane decode
    // ----------------------------------------
    // Mask level of one lane; lanes outside the organisation never write
    function lane_off;
        input [3:0]   masks;
        input integer lane;
        input         org;
        begin
            if (lane > 3)
                lane_off = 1'b1;
            else if ((org == `ORG_18) && (lane > 1))
                lane_off = 1'b1;
            else
                lane_off = masks[lane];
        end
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    // Reset release flops and the released copy
    reg  [1:0]             rst_sync;
    wire                   rst_n;
    // Sequencer registers and their next values
    reg                    state;
    reg                    next_state;
    reg  [`BEAT_CNT_W-1:0] beat;
    reg  [`BEAT_CNT_W-1:0] next_beat;
    reg  [ADDR_W-1:0]      base;
    reg  [ADDR_W-1:0]      next_base;
    reg                    beat_wait;
    reg                    next_beat_wait;
    reg                    req_prev;
    reg                    next_req_prev;
    reg                    next_write_active;
    reg                    next_write_ignored;
    // Storage array; its contents survive reset
    reg  [DW-1:0]          mem [0:(1<<ADDR_W)-1];
    // Beat decode
    wire [3:0]             mask_all;
    wire [LANES-1:0]       mask_n;
    wire [ADDR_W-1:0]      waddr;
    wire [DW-1:0]          old_word;
    wire [DW-1:0]          merged;
    wire                   any_lane;
    wire                   req;
    wire                   take;
    wire                   beat_slot;
    wire                   last_beat;
    wire                   do_write;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    // Assert at once, release two edges later so no flop sees a ragged edge
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn)
            rst_sync <= 2'h0;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // ----------------------------------------
    // Request and beat decode
    // ----------------------------------------
    // Masks as one word, lane 0 in bit 0
    assign mask_all  = {i_lane_mask_3_n, i_lane_mask_2_n,
                        i_lane_mask_1_n, i_lane_mask_0_n};
    // A write request only counts on a true-clock rise
    assign req       = ~i_write_port_select_n & ~i_beat_phase;
    // Accepted only when idle and the previous true rise held no request
    assign take      = (state == S_IDLE) & req & ~req_prev;
    // Data slots of a burst: after the wait slot, one per clock rise
    assign beat_slot = (state == S_DATA) & ~beat_wait;
    assign last_beat = (beat == `LAST_BEAT);
    // Burst address walks A, A+1, A+2, A+3 and wraps with the array
    assign waddr     = base + {{(ADDR_W-`BEAT_CNT_W){1'b0}}, beat};
    assign old_word  = mem[waddr];
    // A beat with every lane masked leaves the word alone
    assign do_write  = beat_slot & any_lane;

    // Per-lane mask of this beat, high for lanes the organisation lacks
    genvar g;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : mask_lane
            assign mask_n[g] = lane_off(mask_all, g, ORG);
        end
    endgenerate

    // ----------------------------------------
    // Lane merge
    // ----------------------------------------
    // Lanes with a low mask come from the beat, the rest from the old word
    sram_lane_merge #(
        .LANES (LANES),
        .LW    (`LANE_W)
    ) u_merge (
        .i_old    (old_word),
        .i_new    (i_data),
        .i_mask_n (mask_n),
        .o_merged (merged),
        .o_any    (any_lane)
    );

    // ----------------------------------------
    // Burst sequencer, next values
    // ----------------------------------------
    // Address on a true rise, wait slot, then four beats on successive rises
    always @* begin
        next_state         = state;
        next_beat          = beat;
        next_base          = base;
        next_beat_wait     = beat_wait;
        next_req_prev      = req_prev;
        next_write_active  = o_write_active;
        next_write_ignored = 1'b0;
        // Remember whether this true rise carried a request
        if (~i_beat_phase)
            next_req_prev = req;
        case (state)
            S_IDLE: begin
                if (take) begin
                    next_base         = i_addr;
                    next_beat         = {`BEAT_CNT_W{1'b0}};
                    next_beat_wait    = 1'b1;
                    next_state        = S_DATA;
                    next_write_active = 1'b1;
                end else if (req) begin
                    // Request right after another one is dropped
                    next_write_ignored = 1'b1;
                end
            end
            S_DATA: begin
                if (beat_wait) begin
                    // Complementary rise of the address cycle carries no data
                    next_beat_wait = 1'b0;
                end else begin
                    next_beat = beat + `BEAT_STEP;
                    if (last_beat) begin
                        next_state        = S_IDLE;
                        next_write_active = 1'b0;
                    end
                end
                // No second burst is queued behind a running one
                if (req)
                    next_write_ignored = 1'b1;
            end
            default: begin
                next_state        = S_IDLE;
                next_write_active = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Burst sequencer, registers
    // ----------------------------------------
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state           <= S_IDLE;
            beat            <= {`BEAT_CNT_W{1'b0}};
            base            <= {ADDR_W{1'b0}};
            beat_wait       <= 1'b0;
            req_prev        <= 1'b0;
            o_write_active  <= 1'b0;
            o_write_ignored <= 1'b0;
        end else begin
            state           <= next_state;
            beat            <= next_beat;
            base            <= next_base;
            beat_wait       <= next_beat_wait;
            req_prev        <= next_req_prev;
            o_write_active  <= next_write_active;
            o_write_ignored <= next_write_ignored;
        end
    end

    // ----------------------------------------
    // Array write
    // ----------------------------------------
    // One beat per rise, each lane stored only under its own low mask
    always @(posedge i_clk) begin
        if (rst_n && do_write)
            mem[waddr] <= merged;
    end

    // ----------------------------------------
    // Read-back port
    // ----------------------------------------
    // Registered read for observation, one clock behind the address
    always @(posedge i_clk or negedge rst_n) begin
        if (!rst_n)
            o_rd_data <= {DW{1'b0}};
        else
            o_rd_data <= mem[i_rd_addr];
    end
endmodule // sram_byte_write_mask
`default_nettype wire

// *** ctl_model.sv ***
// Memory controller model driving the write port
`default_nettype none
module ctl_model (
    // Clock and mask mode
    input  wire logic        i_clk,
    input  wire logic        full,
    // Write port toward the device
    output logic             i_beat_phase,
    output logic             i_write_port_select_n,
    output logic [5:0]       i_addr,
    output logic [35:0]      i_data,
    output logic [3:0]       mk
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {i_beat_phase, i_write_port_select_n, i_addr, i_data, mk} = 48'h4000_0000_0000;
    // Fresh beat and masks every slot, also between bursts
    always @(negedge i_clk) begin
        i_beat_phase <= ~i_beat_phase;
        i_data <= {4'($urandom), $urandom};
        mk <= full ? 4'h0 : 4'($urandom);
    end
    // One request on the next true-clock rise
    task automatic req(input logic [5:0] a);
        @(negedge i_clk iff i_beat_phase);
        i_write_port_select_n <= 1'b0;
        i_addr <= a;
        @(negedge i_clk);
        i_write_port_select_n <= 1'b1;
    endtask
endmodule // ctl_model
`default_nettype wire

// *** sram_wmask_props.sv ***
// Assertions on the lane-masked write port
`default_nettype none
module sram_wmask_props #(parameter ADDR_W = 6, parameter LANES = 4) (
    input wire logic               i_clk,
    input wire logic               i_resetn,
    input wire logic               i_beat_phase,
    input wire logic               i_write_port_select_n,
    input wire logic [ADDR_W-1:0]  i_rd_addr,
    input wire logic [LANES*9-1:0] o_rd_data,
    input wire logic               o_write_active,
    input wire logic               o_write_ignored
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    wire req = !i_beat_phase && !i_write_port_select_n;
    take_len_a: assert property (req && !o_write_active && $past(i_write_port_select_n, 2)
        |=> o_write_active [*5] ##1 !o_write_active) else $error("burst length");
    refuse_a: assert property (req && (o_write_active || !$past(i_write_port_select_n, 2))
        |=> o_write_ignored) else $error("not refused");
    pulse_one_a: assert property (o_write_ignored |=> !o_write_ignored) else $error("pulse");
    ign_cause_a: assert property (o_write_ignored |-> $past(req)) else $error("ign cause");
    start_cause_a: assert property ($rose(o_write_active) |-> $past(req) && !o_write_ignored)
        else $error("start cause");
    end_hold_a: assert property ($fell(o_write_active) |-> $past(o_write_active, 5))
        else $error("short burst");
    busy_keep_a: assert property (req && o_write_active |=> o_write_active) else $error("cut");
    idle_quiet_a: assert property (!o_write_active && !$past(o_write_active) &&
        $past(i_resetn, 4) && $stable(i_rd_addr) |=> $stable(o_rd_data)) else $error("idle write");
endmodule // sram_wmask_props
bind sram_byte_write_mask sram_wmask_props #(.ADDR_W(ADDR_W), .LANES(LANES)) props (.*);
`default_nettype wire

// *** sram_byte_write_mask_tb.sv ***
// Self-checking bench for the lane-masked write port
`default_nettype none
module sram_byte_write_mask_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 0, i_resetn = 0, i_beat_phase, i_write_port_select_n, full = 1, prev = 0;
    logic i_lane_mask_0_n, i_lane_mask_1_n, i_lane_mask_2_n, i_lane_mask_3_n;
    logic o_write_active, o_write_ignored, act_18, ign_18, exp_act = 0, exp_ign = 0;
    logic [3:0] mk;
    logic [5:0] i_addr, i_rd_addr = 0;
    logic [35:0] i_data, o_rd_data, m [64];
    logic [17:0] rd_18, m18 [64];
    int fails = 0, compares = 0, k = 0, base = 0, cyc = 0;
    assign {i_lane_mask_3_n, i_lane_mask_2_n, i_lane_mask_1_n, i_lane_mask_0_n} = mk;
    always #50 i_clk = ~i_clk;
    ctl_model ctl (.*);
    sram_byte_write_mask dut (.*);
    // Narrow organisation on the same stimulus, lanes 0 and 1 only
    sram_byte_write_mask #(.ORG(1'b0), .LANES(2)) dut_18 (
        .i_clk                 (i_clk),
        .i_resetn              (i_resetn),
        .i_beat_phase          (i_beat_phase),
        .i_write_port_select_n (i_write_port_select_n),
        .i_addr                (i_addr),
        .i_data                (i_data[17:0]),
        .i_lane_mask_0_n       (i_lane_mask_0_n),
        .i_lane_mask_1_n       (i_lane_mask_1_n),
        .i_lane_mask_2_n       (i_lane_mask_2_n),
        .i_lane_mask_3_n       (i_lane_mask_3_n),
        .i_rd_addr             (i_rd_addr),
        .o_rd_data             (rd_18),
        .o_write_active        (act_18),
        .o_write_ignored       (ign_18)
    );
    // Reference: take, wait slot, four beats merged lane by lane
    always @(posedge i_clk) begin
        cyc++;
        if (k >= 2)
            for (int g = 0; g < 4; g++)
                if (!mk[g]) begin
                    m[(base + k - 2) % 64][9*g +: 9] = i_data[9*g +: 9];
                    if (g < 2)
                        m18[(base + k - 2) % 64][9*g +: 9] = i_data[9*g +: 9];
                end
        exp_ign = !i_beat_phase && !i_write_port_select_n && (k > 0 || prev);
        if (k > 0)
            k = (k == 5) ? 0 : k + 1;
        else if (!i_beat_phase && !i_write_port_select_n && !prev) begin
            base = i_addr;
            k = 1;
        end
        exp_act = (k > 0);
        if (!i_beat_phase)
            prev = !i_write_port_select_n;
        if (cyc == 5000) begin
            fails++;
            final_report();
        end
    end
    // Status flags compared on every settled half cycle
    always @(negedge i_clk) begin
        if (i_resetn) begin
            check_flag("write_active", exp_act, o_write_active);
            check_flag("write_ignored", exp_ign, o_write_ignored);
            check_flag("write_active_18", exp_act, act_18);
            check_flag("write_ignored_18", exp_ign, ign_18);
        end
    end
    // Compare tasks, one per kind of result
    task automatic check_word(input string name, input logic [35:0] exp, input logic [35:0] got);
        compares++;
        if (exp !== got) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic check_flag(input string name, input logic exp, input logic got);
        compares++;
        if (exp !== got) begin
            fails++;
            $display("[FAIL] %s exp %b got %b", name, exp, got);
        end
    endtask
    // Read back random words while idle and compare with the reference
    task automatic scan(input int n);
        for (int i = 0; i <= n; i++) begin
            @(negedge i_clk);
            if (i > 0) begin
                check_word("rd_data", m[i_rd_addr], o_rd_data);
                check_word("rd_data_18", {18'h0, m18[i_rd_addr]}, {18'h0, rd_18});
            end
            i_rd_addr = 6'($urandom);
        end
    endtask
    // Verdict
    task automatic final_report;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Fill all words, then random masked bursts with refused extra requests
    initial begin
        void'($urandom(32'hD4C3));
        repeat (5) @(negedge i_clk);
        i_resetn = 1;
        repeat (4) @(negedge i_clk);
        for (int i = 0; i < 56; i++) begin
            full <= (i < 16);
            repeat ((i > 24 && i % 4 == 0) ? 4 : 1)
                ctl.req(i < 16 ? 6'(4 * i) : 6'($urandom));
            repeat (6) @(negedge i_clk);
            if (i >= 16)
                scan(6);
        end
        scan(200);
        final_report();
    end
endmodule // sram_byte_write_mask_tb
`default_nettype wire
